/* File: dv/tcv_timer_regs_monitor.sv */
module tcv_timer_regs_monitor
    import tcv_pkg::*;
#(
    parameter int NUM_TRIG = 16
)(
    input wire logic                   clk,
    input wire logic                   resetn,
    input wire logic [7:0]             paddr,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic [NUM_CHAN-1:0]    valueUpdate,
    input wire logic [NUM_TRIG-1:0]    trigIn,
    input wire logic                   counterPaused,
    input wire logic [NUM_CHAN*16-1:0] activeValues,
    input wire logic [NUM_CHAN*2-1:0]  chanModes,
    input wire tcv_trig_t              trigOut
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Helpers
    wire logic selTrig = trigIn[trigOut.trigSel];
    wire logic rdDone  = pready && !pwrite;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_paused; counterPaused [*4]; endsequence
    // ==========================================
    // Properties
    a_ready_after_setup: assert property (s_setup |=> pready && penable)
        else $error("no ready after setup");
    a_err_with_ready: assert property (pslverr |-> pready && psel)
        else $error("error without ready");
    a_status_zero: assert property (rdDone && paddr == FLAG_SUMMARY_OFS |->
        (prdata & ~STATUS_MASK) == 32'h0) else $error("status reserved bits set");
    a_value_upper: assert property (rdDone && paddr >= CHAN_VALUE_BASE_OFS
        && paddr < FLAG_SUMMARY_OFS |-> prdata[31:16] == 16'h0) else $error("value upper set");
    a_compare_buffered: assert property (pready && pwrite && paddr == 8'h18
        && chanModes[3:2] == TCV_MODE_COMPARE && !valueUpdate[1] |=> $stable(activeValues[31:16]))
        else $error("compare write not buffered");
    a_reload_edge: assert property (trigOut.reload |->
        $past(selTrig, 3) && !$past(selTrig, 4)) else $error("reload without edge");
    a_reload_pulse: assert property (trigOut.reload |=> !trigOut.reload)
        else $error("reload longer than one cycle");
    a_pause_blocks: assert property (s_paused |-> !trigOut.reload)
        else $error("reload while paused");
endmodule

bind tcv_timer_regs tcv_timer_regs_monitor #(.NUM_TRIG(NUM_TRIG)) i_mon (
    .clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .valueUpdate(valueUpdate), .trigIn(trigIn), .counterPaused(counterPaused),
    .activeValues(activeValues), .chanModes(chanModes), .trigOut(trigOut));

/* File: dv/tcv_timer_regs_tb.sv */
module tcv_timer_regs_tb
    import tcv_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic                   pwrite = 1'b0, counterPaused = 1'b0, pready, pslverr, irq, er;
    logic [7:0]             paddr = 8'h00;
    logic [31:0]            pwdata = 32'h0, prdata, rd;
    logic [3:0]             pstrb = 4'hF;
    tcv_events_t            events = '0;
    logic [NUM_CHAN*16-1:0] captureValues = {6{16'hABCD}}, activeValues;
    logic [NUM_CHAN-1:0]    valueUpdate = '0;
    logic [15:0]            trigIn;
    logic [NUM_CHAN*2-1:0]  chanModes;
    tcv_trig_t              trigOut;
    int                     num_errors = 0, n_tests = 0, k, seen;

    tcv_timer_regs #(.NUM_TRIG(16)) i_dut (.clk(clk), .resetn(resetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events),
        .captureValues(captureValues), .valueUpdate(valueUpdate), .trigIn(trigIn),
        .counterPaused(counterPaused), .activeValues(activeValues), .trigOut(trigOut),
        .chanModes(chanModes), .irq(irq));
    tcv_trig_source #(.NUM_TRIG(16)) i_src (.clk(clk), .trigLines(trigIn));

    initial forever #2.5 clk = ~clk;

    // ==========================================
    // Tasks
    task automatic give_verdict();
        $display("Checks %0d, errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge clk);
            i++;
        end
        while (pready !== 1'b1 && i < 16);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            num_errors++;
            $display("[ERR] %0t no pready", $time);
            give_verdict();
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    task automatic ev(input tcv_events_t e);
        @(posedge clk);
        events <= e;
        @(posedge clk);
        events <= '0;
    endtask

    // ==========================================
    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        rdc(FLAG_SUMMARY_OFS, 32'h0);
        apb(1'b0, 8'h04, 32'h0);
        check({rd[30:0], er}, 32'h1);
        apb(1'b1, CHAN_MODE_OFS, 32'h0AA9);
        rdc(CHAN_MODE_OFS, 32'h0AA9);
        check({20'h0, chanModes}, 32'h0AA9);
        apb(1'b1, CHAN_VALUE_BASE_OFS, 32'hFFFF_1234);
        rdc(CHAN_VALUE_BASE_OFS, 32'h0);
        ev(7'h01);
        rdc(CHAN_VALUE_BASE_OFS, 32'hABCD);
        for (k = 1; k < NUM_CHAN; k++)
            apb(1'b1, 8'(CHAN_VALUE_BASE_OFS + CHAN_VALUE_STRIDE * k), 32'hFFFF_0100 + k);
        #1 check({16'h0, activeValues[31:16]}, 32'h0);
        @(posedge clk);
        valueUpdate <= 6'h3E;
        @(posedge clk);
        valueUpdate <= '0;
        #1 check({16'h0, activeValues[95:80]}, 32'h0105);
        for (k = 1; k < NUM_CHAN; k++)
            rdc(8'(CHAN_VALUE_BASE_OFS + CHAN_VALUE_STRIDE * k), 32'h0100 + k);
        pstrb <= 4'h3;
        apb(1'b1, 8'h18, 32'h7777);
        pstrb <= 4'hF;
        rdc(8'h18, 32'h0101);
        ev(7'h7F);
        rdc(FLAG_SUMMARY_OFS, 32'h013F);
        #1 check({31'h0, irq}, 32'h0);
        apb(1'b1, IRQ_MASK_OFS, 32'h013F);
        // Irq is registered behind the mask, so it follows one edge later
        @(posedge clk);
        #1 check({31'h0, irq}, 32'h1);
        apb(1'b1, FLAG_SUMMARY_OFS, 32'h0);
        apb(1'b1, FLAG_SUMMARY_OFS, 32'h1);
        rdc(FLAG_SUMMARY_OFS, 32'h013E);
        apb(1'b1, FLAG_SUMMARY_OFS, 32'hFFFF_FFFF);
        rdc(FLAG_SUMMARY_OFS, 32'h0);
        #1 check({31'h0, irq}, 32'h0);
        ev(7'h04);
        // Event lands on the same edge as the clearing write
        fork
            apb(1'b1, FLAG_SUMMARY_OFS, 32'h4);
            begin
                repeat (2) @(posedge clk);
                events <= 7'h04;
                @(posedge clk);
                events <= '0;
            end
        join
        rdc(FLAG_SUMMARY_OFS, 32'h4);
        #1 check({31'h0, irq}, 32'h1);
        for (k = 0; k < 4; k++)
        begin
            apb(1'b1, TIMER_CONFIG_OFS, (k == 1) ? 32'h0300_0000 : 32'h0304_0000);
            counterPaused <= (k == 2);
            seen = 0;
            fork
                i_src.pulse((k == 3) ? 5 : 3);
                repeat (10) @(posedge clk) seen += (trigOut.reload === 1'b1);
            join
            check(32'(seen), {31'h0, k == 0});
            check({28'h0, trigOut.trigSel}, 32'h3);
        end
        counterPaused <= 1'b0;
        rdc(TIMER_CONFIG_OFS, 32'h0304_0000);
        give_verdict();
    end
endmodule

/* File: dv/tcv_trig_source.sv */
module tcv_trig_source
#(
    parameter int NUM_TRIG = 16
)(
    input  wire logic          clk,
    output logic [NUM_TRIG-1:0] trigLines
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Level held six cycles so the synchroniser sees it
    initial trigLines = '0;
    task automatic pulse(input int k);
        @(posedge clk);
        trigLines[k] <= 1'b1;
        repeat (6) @(posedge clk);
        trigLines[k] <= 1'b0;
    endtask
endmodule

/* File: src/tcv_pkg.sv */
package tcv_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] CHAN_VALUE_BASE_OFS = 8'h10;
    localparam logic [7:0] CHAN_VALUE_STRIDE   = 8'h08;
    localparam logic [7:0] FLAG_SUMMARY_OFS    = 8'h50;
    localparam logic [7:0] TIMER_CONFIG_OFS    = 8'h54;
    localparam logic [7:0] IRQ_MASK_OFS        = 8'h58;
    localparam logic [7:0] CHAN_MODE_OFS       = 8'h5C;

    // ==========================================================
    // Field positions
    localparam int VALUE_MSB        = 15;
    localparam int OVERFLOW_BIT     = 8;
    localparam int RELOAD_TRIG_BIT  = 18;
    localparam int TRIG_SEL_LSB     = 24;
    localparam int TRIG_SEL_MSB     = 27;
    localparam int NUM_CHAN         = 6;

    // ==========================================================
    // Reset values
    localparam logic [15:0] VALUE_RESET  = 16'h0000;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam logic [8:0]  MASK_RESET   = 9'h000;

    // Writable bits of the configuration register
    localparam logic [31:0] CONFIG_WMASK = 32'h0F04_0000;
    // Status bits that exist
    localparam logic [31:0] STATUS_MASK  = 32'h0000_013F;

    // ==========================================================
    // Channel mode, two bits per channel in the mode register
    typedef enum logic [1:0] {
        TCV_MODE_OFF     = 2'h0,
        TCV_MODE_CAPTURE = 2'h1,
        TCV_MODE_COMPARE = 2'h2
    } tcv_mode_t;

    // Event inputs grouped together
    typedef struct packed {
        logic                overflow;
        logic [NUM_CHAN-1:0] chan;
    } tcv_events_t;

    // Reload request toward the counter
    typedef struct packed {
        logic       reload;
        logic [3:0] trigSel;
    } tcv_trig_t;

endpackage

/* File: src/tcv_timer_regs.sv */
// Notes on behaviour
// - Capture-mode channel ignores bus writes to its value register.
// - Compare-mode value write lands in a per-channel buffer, moved on update.
// - Value register holds 16-bit capture or match value; upper bits read zero.
// - Value register i decodes at 10h plus 8 times i.
// - Status bits 5..0 mirror the six channel event flags.
// - Status bit 8 mirrors overflow; bits 31..9 and 7..6 read zero.
// - A channel event sets that channel's flag.
// - Writing one clears a flag, writing zero leaves it.
// - Event coinciding with a clearing write keeps the flag set.
// - Flag kept set keeps its interrupt request asserted.
// - Configuration bits 27..24 select the trigger source.
// - With reload bit 18 set, trigger rising edge zeroes counter, resets outputs.
// - With reload bit clear, trigger edges do not reload.
// - Trigger ignored while counter paused in debug or doze.
module tcv_timer_regs
    import tcv_pkg::*;
#(
    parameter int NUM_TRIG = 16
)(
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic [7:0]            paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire tcv_events_t           events,
    input  wire logic [NUM_CHAN*16-1:0] captureValues,
    input  wire logic [NUM_CHAN-1:0]   valueUpdate,
    input  wire logic [NUM_TRIG-1:0]   trigIn,
    input  wire logic                  counterPaused,
    output logic [NUM_CHAN*16-1:0]     activeValues,
    output tcv_trig_t                  trigOut,
    output logic [NUM_CHAN*2-1:0]      chanModes,
    output logic                       irq
);

    // Refused at elaboration: the selector is only four bits wide
    if (NUM_TRIG < 1 || NUM_TRIG > 16)
    begin : g_badTrigCount
        $error("NUM_TRIG must be 1 to 16");
    end

    // ==========================================================
    // Address decode
    function automatic logic isValueAddr(input logic [7:0] a, input int i);
        return a == 8'(CHAN_VALUE_BASE_OFS + CHAN_VALUE_STRIDE * i);
    endfunction

    wire logic access     = psel && penable;
    wire logic wrAccess   = access && pwrite;
    wire logic fullWord   = pstrb == 4'hF;
    wire logic hitStatus  = paddr == FLAG_SUMMARY_OFS;
    wire logic hitConfig  = paddr == TIMER_CONFIG_OFS;
    wire logic hitMask    = paddr == IRQ_MASK_OFS;
    wire logic hitMode    = paddr == CHAN_MODE_OFS;
    logic [NUM_CHAN-1:0] hitValue;
    logic                hitAny;

    always_comb
    begin
        for (int i = 0; i < NUM_CHAN; i++)
            hitValue[i] = isValueAddr(paddr, i);
        hitAny = (|hitValue) || hitStatus || hitConfig || hitMask || hitMode;
    end

    // ==========================================================
    // Registers
    logic [15:0]         valueBuf_reg [NUM_CHAN];
    logic [15:0]         value_reg    [NUM_CHAN];
    logic [NUM_CHAN-1:0] bufPending_reg;
    logic [NUM_CHAN-1:0] chanFlag_reg;
    logic                overflowFlag_reg;
    logic [31:0]         config_reg;
    logic [8:0]          mask_reg;
    logic [NUM_CHAN*2-1:0] mode_reg;
    logic [31:0]         prdata_reg;
    logic                pready_reg;
    logic                pslverr_reg;
    logic                irq_reg;
    logic [1:0]          trigSync_reg;
    logic                trigPrev_reg;
    tcv_trig_t           trigOut_reg;

    // ==========================================================
    // Channel value registers
    logic [NUM_CHAN-1:0] chanCapture;
    logic [NUM_CHAN-1:0] chanCompare;
    logic [NUM_CHAN-1:0] valueWrite;

    always_comb
    begin
        for (int i = 0; i < NUM_CHAN; i++)
        begin
            chanCapture[i] = tcv_mode_t'(mode_reg[2*i +: 2]) == TCV_MODE_CAPTURE;
            chanCompare[i] = tcv_mode_t'(mode_reg[2*i +: 2]) == TCV_MODE_COMPARE;
            // Partial writes are dropped; software must write whole words
            valueWrite[i]  = wrAccess && hitValue[i] && fullWord;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < NUM_CHAN; i++)
            begin
                valueBuf_reg[i] <= VALUE_RESET;
                value_reg[i]    <= VALUE_RESET;
            end
            bufPending_reg <= '0;
        end
        else
        begin
            for (int i = 0; i < NUM_CHAN; i++)
            begin
                if (chanCapture[i] && events.chan[i])
                    value_reg[i] <= captureValues[16*i +: 16];
                else if (valueUpdate[i] && bufPending_reg[i])
                    value_reg[i] <= valueBuf_reg[i];
                if (valueWrite[i] && chanCompare[i])
                begin
                    valueBuf_reg[i]   <= pwdata[VALUE_MSB:0];
                    bufPending_reg[i] <= 1'b1;
                end
                else if (valueUpdate[i])
                    bufPending_reg[i] <= 1'b0;
                // Capture mode: write falls through untouched
            end
        end
    end

    // ==========================================================
    // Event flags
    wire logic statusWr = wrAccess && hitStatus && fullWord;
    wire logic [NUM_CHAN-1:0] clearChan = statusWr ? pwdata[NUM_CHAN-1:0] : '0;
    wire logic clearOvf = statusWr && pwdata[OVERFLOW_BIT];
    // Set beats clear so a fresh event is never lost
    wire logic [NUM_CHAN-1:0] chanFlag_next =
        events.chan | (chanFlag_reg & ~clearChan);
    wire logic overflowFlag_next = events.overflow | (overflowFlag_reg & ~clearOvf);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            chanFlag_reg     <= '0;
            overflowFlag_reg <= 1'b0;
        end
        else
        begin
            chanFlag_reg     <= chanFlag_next;
            overflowFlag_reg <= overflowFlag_next;
        end
    end

    wire logic [31:0] statusWord = {23'h0, overflowFlag_reg, 2'h0, chanFlag_reg};

    // ==========================================================
    // Configuration, mask, mode
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            config_reg <= CONFIG_RESET;
            mask_reg   <= MASK_RESET;
            mode_reg   <= '0;
        end
        else
        begin
            if (wrAccess && hitConfig && fullWord)
                config_reg <= pwdata & CONFIG_WMASK;
            if (wrAccess && hitMask && fullWord)
                mask_reg <= pwdata[8:0] & STATUS_MASK[8:0];
            if (wrAccess && hitMode && fullWord)
                mode_reg <= pwdata[NUM_CHAN*2-1:0];
        end
    end

    // ==========================================================
    // Interrupt: uses next flag value so a set/clear race keeps it high
    wire logic irq_next = |({overflowFlag_next, 2'b00, chanFlag_next} & mask_reg);

    // ==========================================================
    // Trigger path
    wire logic [3:0] trigSel  = config_reg[TRIG_SEL_MSB:TRIG_SEL_LSB];
    // Selecting a source at or above NUM_TRIG reads as a quiet input
    wire logic trigSelected   = (32'(trigSel) < NUM_TRIG) ? trigIn[trigSel] : 1'b0;
    wire logic trigRise       = trigSync_reg[1] && !trigPrev_reg;
    wire logic reloadEnable   = config_reg[RELOAD_TRIG_BIT];
    wire logic reload_next    = trigRise && reloadEnable && !counterPaused;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            trigSync_reg <= 2'b00;
            trigPrev_reg <= 1'b0;
            trigOut_reg  <= '0;
            irq_reg      <= 1'b0;
        end
        else
        begin
            trigSync_reg <= {trigSync_reg[0], trigSelected};
            trigPrev_reg <= trigSync_reg[1];
            trigOut_reg  <= '{reload: reload_next, trigSel: trigSel};
            irq_reg      <= irq_next;
        end
    end

    // ==========================================================
    // APB read and answer: one wait-free access phase
    logic [31:0] readMux;

    always_comb
    begin
        readMux = 32'h0;
        for (int i = 0; i < NUM_CHAN; i++)
            if (hitValue[i])
                readMux = {16'h0, value_reg[i]};
        if (hitStatus)
            readMux = statusWord;
        if (hitConfig)
            readMux = config_reg;
        if (hitMask)
            readMux = {23'h0, mask_reg};
        if (hitMode)
            readMux = {{(32 - NUM_CHAN*2){1'b0}}, mode_reg};
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prdata_reg  <= 32'h0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg  <= psel && !penable && !pready_reg;
            pslverr_reg <= psel && !penable && !hitAny;
            prdata_reg  <= (psel && !penable && !pwrite) ? readMux : 32'h0;
        end
    end

    // ==========================================================
    // Outputs
    always_comb
    begin
        for (int i = 0; i < NUM_CHAN; i++)
            activeValues[16*i +: 16] = value_reg[i];
    end

    assign prdata    = prdata_reg;
    assign pready    = pready_reg;
    assign pslverr   = pslverr_reg;
    assign irq       = irq_reg;
    assign trigOut   = trigOut_reg;
    assign chanModes = mode_reg;

endmodule
